// ### core/psc_pkg.sv
// Shared constants for the pump staging controller
package psc_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int SEC_S = 1;
  localparam int CYC_PER_SEC = CLK_HZ * SEC_S;
  localparam int SEC_W = 15;
  localparam int VAL_W = 9;
  localparam int HZ_W = 7;
  localparam int ADC_W = 12;
  localparam int CNT_W = 8;
  localparam int NPUMP = 4;
  // Level setpoints held in tenths of a foot
  localparam logic [8:0] LVL_DEF = 9'h032;
  localparam logic [8:0] LVL_MIN = 9'h005;
  localparam logic [8:0] LVL_MAX = 9'h1F4;
  localparam logic [8:0] FLOW_DEF = 9'h014;
  localparam logic [8:0] FLOW_MIN = 9'h00A;
  localparam logic [8:0] FLOW_MAX = 9'h140;
  localparam logic [8:0] SUC_LVL_MAX = 9'h0C8;
  localparam logic [8:0] SUC_RNG_MIN = 9'h01E;
  localparam logic [8:0] SUC_RNG_MAX = 9'h1F4;
  localparam logic [14:0] SUC_TIME_MAX = 15'h4650;
  localparam logic [14:0] DELAY_MAX = 15'h0E10;
  localparam logic [8:0] MARGIN_MAX = 9'h0C8;
  localparam logic [6:0] HZ_MAX = 7'h78;
  localparam logic [2:0] PUMP_MAX = 3'h4;
  localparam logic [11:0] ADC_FULL = 12'hFFF;
  localparam logic [0:0] SP_LEVEL = 1'h0;
  localparam logic [0:0] SP_FLOW = 1'h1;
endpackage

// ### core/psc_timer.sv
// Seconds timer that restarts whenever its run level drops
`timescale 1ns/10ps
module psc_timer #(
  parameter int W = 15
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic run_in,
  input wire logic tick_in,
  input wire logic [W-1:0] limit_in,
  output logic done_out
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !run_in) begin
      cnt <= '0;
    end else if (tick_in && cnt < limit_in) begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= run_in && cnt >= limit_in;
    end
  end
endmodule

// ### core/psc_scale.sv
// Scales a raw transducer code to psi, optionally inverted
`timescale 1ns/10ps
module psc_scale (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [11:0] raw_in,
  input wire logic [8:0] range_in,
  input wire logic invert_in,
  output logic [8:0] psi_out
);
  logic [11:0] code;
  logic [20:0] prod;

  always_comb begin
    code = invert_in ? psc_pkg::ADC_FULL - raw_in : raw_in;
    prod = code * range_in;
  end

  // Divide by 4096 rather than 4095: full scale reads one count low
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      psi_out <= '0;
    end else begin
      psi_out <= prod[20:12];
    end
  end
endmodule

// ### core/psc_core.sv
// Pump staging controller: setpoints, suction fault, lead/lag staging
`timescale 1ns/10ps
module psc_core #(
  parameter int TICKS_PER_SEC = psc_pkg::CYC_PER_SEC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic sp_wr_in,
  input wire logic sp_kind_in,
  input wire logic [1:0] sp_idx_in,
  input wire logic [8:0] sp_val_in,
  input wire logic [1:0] sp_sel_in,
  output logic [8:0] level_target_out,
  output logic [8:0] flow_target_out,
  input wire logic [11:0] suction_raw_in,
  input wire logic [8:0] suction_level_in,
  input wire logic [14:0] suction_time_in,
  input wire logic [8:0] suction_range_in,
  input wire logic suction_invert_in,
  output logic [8:0] suction_psi_out,
  output logic suction_fault_out,
  input wire logic constant_pressure_control_in,
  input wire logic [8:0] pressure_in,
  input wire logic [8:0] control_psi_in,
  input wire logic [6:0] freq_in,
  input wire logic [6:0] min_freq_in,
  input wire logic [6:0] max_freq_in,
  input wire logic [2:0] num_lag_in,
  input wire logic [14:0] stage_delay_in,
  input wire logic [14:0] destage_delay_in,
  input wire logic [14:0] stage_time_in,
  input wire logic [14:0] destage_time_in,
  input wire logic [27:0] stage_reduce_in,
  input wire logic [27:0] destage_boost_in,
  input wire logic [8:0] stage_margin_in,
  input wire logic [8:0] destage_margin_in,
  input wire logic [6:0] destage_min_offset_in,
  input wire logic precharge_in,
  input wire logic [2:0] precharge_pumps_in,
  output logic [3:0] relay_out,
  output logic [2:0] lag_count_out,
  output logic [6:0] freq_reduce_out,
  output logic [6:0] freq_boost_out,
  input wire logic clear_memory_in,
  input wire logic auto_restart_en_in,
  input wire logic [14:0] restart_delay_in,
  input wire logic key_up_in,
  input wire logic key_down_in,
  output logic restart_go_out,
  output logic [7:0] fault_count_out,
  output logic [7:0] restart_count_out
);
  function automatic logic [8:0] clamp9(input logic [8:0] v,
                                        input logic [8:0] lo,
                                        input logic [8:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  function automatic logic [14:0] cap15(input logic [14:0] v,
                                        input logic [14:0] hi);
    return (v > hi) ? hi : v;
  endfunction

  function automatic logic [6:0] cap7(input logic [6:0] v);
    return (v > psc_pkg::HZ_MAX) ? psc_pkg::HZ_MAX : v;
  endfunction

  // Pin synchronisers; first stage feeds only the second
  logic [11:0] suc_s1, suc_s2;
  logic [8:0] prs_s1, prs_s2;
  logic [1:0] key_s1, key_s2;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      suc_s1 <= '0;
      suc_s2 <= '0;
      prs_s1 <= '0;
      prs_s2 <= '0;
      key_s1 <= '0;
      key_s2 <= '0;
    end else begin
      suc_s1 <= suction_raw_in;
      suc_s2 <= suc_s1;
      prs_s1 <= pressure_in;
      prs_s2 <= prs_s1;
      key_s1 <= {key_up_in, key_down_in};
      key_s2 <= key_s1;
    end
  end

  // One-second tick
  logic [24:0] tick_cnt;
  logic tick;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || tick_cnt == 25'(TICKS_PER_SEC - 1)) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end
  assign tick = tick_cnt == 25'(TICKS_PER_SEC - 1);

  // Setpoint storage
  logic [8:0] lvl_sp [psc_pkg::NPUMP];
  logic [8:0] flow_sp [psc_pkg::NPUMP];
  genvar gi;
  generate
    for (gi = 0; gi < psc_pkg::NPUMP; gi++) begin : g_sp
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          lvl_sp[gi] <= psc_pkg::LVL_DEF;
          flow_sp[gi] <= psc_pkg::FLOW_DEF;
        end else if (sp_wr_in && sp_idx_in == 2'(gi)) begin
          if (sp_kind_in == psc_pkg::SP_LEVEL) begin
            lvl_sp[gi] <= clamp9(sp_val_in, psc_pkg::LVL_MIN,
                                 psc_pkg::LVL_MAX);
          end else begin
            flow_sp[gi] <= clamp9(sp_val_in, psc_pkg::FLOW_MIN,
                                  psc_pkg::FLOW_MAX);
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      level_target_out <= psc_pkg::LVL_DEF;
      flow_target_out <= psc_pkg::FLOW_DEF;
    end else begin
      level_target_out <= lvl_sp[sp_sel_in];
      flow_target_out <= flow_sp[sp_sel_in];
    end
  end

  // Suction supervision
  logic [8:0] suc_range;
  logic low_suction;
  assign suc_range = clamp9(suction_range_in, psc_pkg::SUC_RNG_MIN,
                            psc_pkg::SUC_RNG_MAX);
  psc_scale u_scale (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .raw_in(suc_s2),
    .range_in(suc_range),
    .invert_in(suction_invert_in),
    .psi_out(suction_psi_out)
  );
  assign low_suction = suction_psi_out < clamp9(suction_level_in, '0,
                       psc_pkg::SUC_LVL_MAX);
  psc_timer #(.W(psc_pkg::SEC_W)) u_suc_tmr (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(low_suction),
    .tick_in(tick),
    .limit_in(cap15(suction_time_in, psc_pkg::SUC_TIME_MAX)),
    .done_out(suction_fault_out)
  );

  // Staging conditions
  logic [2:0] num_lag;
  logic [9:0] prs_w, ctl_w;
  logic at_max, at_min, stage_cond, destage_cond;
  logic stage_done, destage_done, stage_fire, destage_fire;
  logic stage_win, destage_win, swin_done, dwin_done;
  assign num_lag = (num_lag_in > psc_pkg::PUMP_MAX) ? psc_pkg::PUMP_MAX
                   : num_lag_in;
  assign prs_w = {1'b0, prs_s2};
  assign ctl_w = {1'b0, control_psi_in};
  assign at_max = freq_in >= max_freq_in;
  assign at_min = {1'b0, freq_in} <=
                  {1'b0, min_freq_in} + {1'b0, cap7(destage_min_offset_in)};
  assign stage_cond = constant_pressure_control_in && at_max
    && lag_count_out < num_lag
    && prs_w + {1'b0, clamp9(stage_margin_in, '0, psc_pkg::MARGIN_MAX)}
       < ctl_w;
  assign destage_cond = constant_pressure_control_in && at_min
    && lag_count_out != '0
    && prs_w > ctl_w
       + {1'b0, clamp9(destage_margin_in, '0, psc_pkg::MARGIN_MAX)};

  // Run drops in the fire cycle so each timeout stages or destages exactly one pump
  psc_timer #(.W(psc_pkg::SEC_W)) u_stg_tmr (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(stage_cond && !stage_fire),
    .tick_in(tick),
    .limit_in(cap15(stage_delay_in, psc_pkg::DELAY_MAX)),
    .done_out(stage_done)
  );
  psc_timer #(.W(psc_pkg::SEC_W)) u_dst_tmr (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(destage_cond && !destage_fire),
    .tick_in(tick),
    .limit_in(cap15(destage_delay_in, psc_pkg::DELAY_MAX)),
    .done_out(destage_done)
  );

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      stage_fire <= 1'b0;
      destage_fire <= 1'b0;
    end else begin
      stage_fire <= stage_done && stage_cond && !stage_fire;
      destage_fire <= destage_done && destage_cond && !destage_fire
                      && !(stage_done && stage_cond);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      lag_count_out <= '0;
    end else if (!constant_pressure_control_in) begin
      lag_count_out <= '0;
    end else if (stage_fire) begin
      lag_count_out <= lag_count_out + 1'b1;
    end else if (destage_fire) begin
      lag_count_out <= lag_count_out - 1'b1;
    end
  end

  // Frequency reduction and boost windows
  psc_timer #(.W(psc_pkg::SEC_W)) u_swin_tmr (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(stage_win && !stage_fire),
    .tick_in(tick),
    .limit_in(cap15(stage_time_in, psc_pkg::DELAY_MAX)),
    .done_out(swin_done)
  );
  psc_timer #(.W(psc_pkg::SEC_W)) u_dwin_tmr (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(destage_win && !destage_fire),
    .tick_in(tick),
    .limit_in(cap15(destage_time_in, psc_pkg::DELAY_MAX)),
    .done_out(dwin_done)
  );

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      stage_win <= 1'b0;
      freq_reduce_out <= '0;
    end else if (stage_fire) begin
      stage_win <= 1'b1;
      freq_reduce_out <= cap7(stage_reduce_in[lag_count_out[1:0]*7 +: 7]);
    end else if (swin_done) begin
      stage_win <= 1'b0;
      freq_reduce_out <= '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      destage_win <= 1'b0;
      freq_boost_out <= '0;
    end else if (destage_fire) begin
      destage_win <= 1'b1;
      freq_boost_out <=
        cap7(destage_boost_in[{lag_count_out[1:0] - 2'h1}*7 +: 7]);
    end else if (dwin_done) begin
      destage_win <= 1'b0;
      freq_boost_out <= '0;
    end
  end

  // Relays: lag pumps fill from relay one, precharge also fills its own count from relay one
  logic [2:0] pre_n;
  assign pre_n = (precharge_pumps_in > psc_pkg::PUMP_MAX)
                 ? psc_pkg::PUMP_MAX : precharge_pumps_in;
  generate
    for (gi = 0; gi < psc_pkg::NPUMP; gi++) begin : g_rly
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          relay_out[gi] <= 1'b0;
        end else begin
          relay_out[gi] <= lag_count_out > 3'(gi)
                           || (precharge_in && pre_n > 3'(gi));
        end
      end
    end
  endgenerate

  // Auto-restart countdown after a suction fault
  logic fault_q, pending, rst_done, keys_both;
  assign keys_both = key_s2 == 2'b11;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= suction_fault_out;
    end
  end
  psc_timer #(.W(psc_pkg::SEC_W)) u_rst_tmr (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(pending),
    .tick_in(tick),
    .limit_in(restart_delay_in),
    .done_out(rst_done)
  );
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pending <= 1'b0;
      restart_go_out <= 1'b0;
    end else begin
      restart_go_out <= pending && (rst_done || keys_both);
      if (pending && (rst_done || keys_both)) begin
        pending <= 1'b0;
      end else if (suction_fault_out && !fault_q && auto_restart_en_in) begin
        pending <= 1'b1;
      end
    end
  end

  // Counting wins over clear so a coincident event is kept
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      fault_count_out <= '0;
    end else if (suction_fault_out && !fault_q) begin
      fault_count_out <= clear_memory_in ? 8'h01 : fault_count_out + 1'b1;
    end else if (clear_memory_in) begin
      fault_count_out <= '0;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      restart_count_out <= '0;
    end else if (restart_go_out) begin
      restart_count_out <= clear_memory_in ? 8'h01
                           : restart_count_out + 1'b1;
    end else if (clear_memory_in) begin
      restart_count_out <= '0;
    end
  end

  chk_relays_ordered: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !precharge_in ##1 !$past(precharge_in) |->
    relay_out == 4'((5'h01 << $past(lag_count_out)) - 5'h01))
    else $error("relays not in ascending order");
  chk_lag_limit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    lag_count_out <= psc_pkg::PUMP_MAX)
    else $error("lag count above four");
  chk_stage_step: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    stage_fire && constant_pressure_control_in |=>
    lag_count_out == $past(lag_count_out) + 3'h1)
    else $error("stage did not add one pump");
  chk_stage_cancel: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !stage_cond |=> !stage_fire)
    else $error("stage fired without condition");
  chk_cp_only: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !constant_pressure_control_in |=> lag_count_out == '0)
    else $error("staging outside constant pressure");
  chk_reduce_window: assert property (@(posedge clk_in)
    disable iff (!rst_b_in)
    !stage_win |-> freq_reduce_out == '0)
    else $error("reduction outside stage window");
  chk_suction_fault: assert property (@(posedge clk_in)
    disable iff (!rst_b_in)
    !low_suction |=> !suction_fault_out)
    else $error("suction fault without low suction");
  chk_key_abort: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pending && keys_both |=> restart_go_out ##1 !pending)
    else $error("keys did not abort countdown");
  chk_clear_mem: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clear_memory_in && !restart_go_out |=> restart_count_out == '0)
    else $error("clear memory left restart count");
endmodule

// ### tb/psc_plant.sv
// Behavioural model of the transducers and the auxiliary pump relay bank
`timescale 1ns/10ps
module psc_plant (
  input wire logic clk_in,
  input wire logic [8:0] psi_cmd_in,
  input wire logic [11:0] suc_cmd_in,
  input wire logic [3:0] relay_in,
  output logic [8:0] pressure_out,
  output logic [11:0] suction_raw_out,
  output logic [3:0] running_out
);
  // Transducers are sampled every rising edge; a called pump starts a cycle later
  always_ff @(posedge clk_in) begin
    pressure_out <= psi_cmd_in;
    suction_raw_out <= suc_cmd_in;
    running_out <= relay_in;
  end
endmodule

// ### tb/psc_core_tb.sv
// Self-checking bench for the pump staging controller
`timescale 1ns/10ps
module psc_core_tb;
  logic clk_in = 1'b0;
  logic rst_b = 1'b0;
  logic sp_wr = 0, sp_kind = 0, cp = 1, invert = 0, precharge = 0;
  logic clear_mem = 0, auto_en = 1, key_up = 0, key_down = 0;
  logic [1:0] sp_idx = 2'h0, sp_sel = 2'h0;
  logic [8:0] sp_val = 9'h000, suc_level = 9'h000, suc_range = 9'h096;
  logic [8:0] psi_cmd = 9'h03C, control = 9'h03C;
  logic [8:0] st_margin = 9'h005, de_margin = 9'h003;
  logic [11:0] suc_cmd = 12'hFFF;
  logic [14:0] suc_time = 15'h0003, st_delay = 15'h0004, de_delay = 15'h0004;
  logic [14:0] st_time = 15'h0001, de_time = 15'h0001, rs_delay = 15'h0064;
  logic [6:0] freq = 7'h28, min_f = 7'h14, max_f = 7'h3C, offset = 7'h05;
  logic [2:0] num_lag = 3'h2, pre_pumps = 3'h3;
  logic [27:0] reduce = 28'h1624487;
  logic [27:0] boost = 28'h1E3868C;
  logic [8:0] pressure, level_t, flow_t, suc_psi;
  logic [11:0] suc_raw;
  logic [3:0] relay;
  logic [2:0] lag;
  logic [6:0] f_red, f_bst;
  logic fault, go;
  logic [7:0] f_cnt, r_cnt;
  int errors = 0;
  int check_count = 0;

  always #25 clk_in = ~clk_in;

  psc_plant plant_u (.clk_in(clk_in), .psi_cmd_in(psi_cmd),
    .suc_cmd_in(suc_cmd), .relay_in(relay), .pressure_out(pressure),
    .suction_raw_out(suc_raw), .running_out());

  psc_core #(.TICKS_PER_SEC(10)) dut_u (.clk_in(clk_in), .rst_b_in(rst_b),
    .sp_wr_in(sp_wr), .sp_kind_in(sp_kind), .sp_idx_in(sp_idx),
    .sp_val_in(sp_val), .sp_sel_in(sp_sel), .level_target_out(level_t),
    .flow_target_out(flow_t), .suction_raw_in(suc_raw),
    .suction_level_in(suc_level), .suction_time_in(suc_time),
    .suction_range_in(suc_range), .suction_invert_in(invert),
    .suction_psi_out(suc_psi), .suction_fault_out(fault),
    .constant_pressure_control_in(cp), .pressure_in(pressure),
    .control_psi_in(control), .freq_in(freq), .min_freq_in(min_f),
    .max_freq_in(max_f), .num_lag_in(num_lag), .stage_delay_in(st_delay),
    .destage_delay_in(de_delay), .stage_time_in(st_time),
    .destage_time_in(de_time), .stage_reduce_in(reduce),
    .destage_boost_in(boost), .stage_margin_in(st_margin),
    .destage_margin_in(de_margin), .destage_min_offset_in(offset),
    .precharge_in(precharge), .precharge_pumps_in(pre_pumps),
    .relay_out(relay), .lag_count_out(lag), .freq_reduce_out(f_red),
    .freq_boost_out(f_bst), .clear_memory_in(clear_mem),
    .auto_restart_en_in(auto_en), .restart_delay_in(rs_delay),
    .key_up_in(key_up), .key_down_in(key_down), .restart_go_out(go),
    .fault_count_out(f_cnt), .restart_count_out(r_cnt));

  localparam int O_LAG = 0;
  localparam int O_FAULT = 1;
  localparam int O_GO = 2;

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [27:0] exp,
                     input logic [27:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic nx(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  function automatic logic [27:0] obs(input int sel);
    case (sel)
      O_LAG: obs = {25'h0, lag};
      O_FAULT: obs = {27'h0, fault};
      default: obs = {27'h0, go};
    endcase
  endfunction

  // Bounded wait sampled at the falling edge, where outputs have settled
  task automatic wait_eq(input int sel, input logic [27:0] exp,
                         input int lim, input string what);
    int n;
    n = 0;
    while (obs(sel) !== exp && n < lim) begin
      @(negedge clk_in);
      n++;
    end
    if (obs(sel) !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen timeout", what, exp);
      final_report();
    end
  endtask

  task automatic wr_sp(input logic k, input logic [1:0] i,
                       input logic [8:0] v);
    @(posedge clk_in);
    sp_wr <= 1'b1;
    sp_kind <= k;
    sp_idx <= i;
    sp_val <= v;
    @(posedge clk_in);
    sp_wr <= 1'b0;
  endtask

  task automatic t_reset();
    nx(1);
    chk("level_t", 28'h032, level_t);
    chk("flow_t", 28'h014, flow_t);
    chk("relay", 28'h0, relay);
    chk("lag", 28'h0, lag);
    chk("fault", 28'h0, fault);
    $display("test reset done");
  endtask

  task automatic t_setpoints();
    logic [8:0] lv [4] = '{9'h032, 9'h1F4, 9'h005, 9'h032};
    logic [8:0] fl [4] = '{9'h0C8, 9'h014, 9'h014, 9'h140};
    // Out-of-range values land on the nearest limit
    wr_sp(1'b0, 2'h1, 9'h1FF);
    wr_sp(1'b0, 2'h2, 9'h002);
    wr_sp(1'b1, 2'h3, 9'h190);
    wr_sp(1'b1, 2'h0, 9'h0C8);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      sp_sel <= 2'(i);
      nx(3);
      chk("level_t", {19'h0, lv[i]}, level_t);
      chk("flow_t", {19'h0, fl[i]}, flow_t);
    end
    $display("test setpoints done");
  endtask

  task automatic t_scale();
    @(posedge clk_in);
    suc_cmd <= 12'h800;
    nx(6);
    chk("suc_psi", 28'h04B, suc_psi);
    @(posedge clk_in);
    invert <= 1'b1;
    nx(6);
    chk("suc_psi inv", 28'h04A, suc_psi);
    @(posedge clk_in);
    invert <= 1'b0;
    suc_range <= 9'h1FF;
    nx(6);
    chk("suc_psi hi", 28'h0FA, suc_psi);
    @(posedge clk_in);
    suc_range <= 9'h010;
    nx(6);
    chk("suc_psi lo", 28'h00F, suc_psi);
    @(posedge clk_in);
    suc_range <= 9'h096;
    suc_cmd <= 12'hFFF;
    $display("test scale done");
  endtask

  task automatic t_fault();
    @(posedge clk_in);
    suc_level <= 9'h032;
    suc_cmd <= 12'h400;
    nx(15);
    chk("fault early", 28'h0, fault);
    wait_eq(O_FAULT, 28'h1, 40, "fault");
    nx(2);
    chk("f_cnt", 28'h01, f_cnt);
    @(posedge clk_in);
    key_up <= 1'b1;
    key_down <= 1'b1;
    wait_eq(O_GO, 28'h1, 10, "restart_go");
    @(posedge clk_in);
    key_up <= 1'b0;
    key_down <= 1'b0;
    nx(2);
    chk("r_cnt", 28'h01, r_cnt);
    @(posedge clk_in);
    clear_mem <= 1'b1;
    @(posedge clk_in);
    clear_mem <= 1'b0;
    suc_cmd <= 12'hFFF;
    nx(1);
    chk("f_cnt clr", 28'h0, f_cnt);
    chk("r_cnt clr", 28'h0, r_cnt);
    nx(6);
    chk("fault gone", 28'h0, fault);
    $display("test fault done");
  endtask

  task automatic t_stage();
    @(posedge clk_in);
    freq <= 7'h3C;
    psi_cmd <= 9'h032;
    nx(28);
    // Exactly at the margin is inside it, so the pending wait restarts
    @(posedge clk_in);
    psi_cmd <= 9'h037;
    nx(5);
    @(posedge clk_in);
    psi_cmd <= 9'h032;
    nx(25);
    chk("lag held", 28'h0, lag);
    wait_eq(O_LAG, 28'h1, 30, "stage one");
    chk("f_red 1", 28'h07, f_red);
    nx(1);
    chk("relay 1", 28'h1, relay);
    nx(22);
    chk("f_red end", 28'h0, f_red);
    chk("lag 1", 28'h1, lag);
    wait_eq(O_LAG, 28'h2, 40, "stage two");
    chk("f_red 2", 28'h09, f_red);
    nx(1);
    chk("relay 2", 28'h3, relay);
    nx(60);
    chk("lag cap", 28'h2, lag);
    $display("test stage done");
  endtask

  task automatic t_destage();
    @(posedge clk_in);
    freq <= 7'h19;
    psi_cmd <= 9'h03F;
    nx(50);
    chk("lag at margin", 28'h2, lag);
    @(posedge clk_in);
    psi_cmd <= 9'h040;
    wait_eq(O_LAG, 28'h1, 50, "destage one");
    chk("f_bst 2", 28'h0D, f_bst);
    nx(1);
    chk("relay d1", 28'h1, relay);
    nx(22);
    chk("f_bst end", 28'h0, f_bst);
    chk("lag d1", 28'h1, lag);
    wait_eq(O_LAG, 28'h0, 40, "destage two");
    chk("f_bst 1", 28'h0C, f_bst);
    $display("test destage done");
  endtask

  task automatic t_mode();
    @(posedge clk_in);
    freq <= 7'h3C;
    psi_cmd <= 9'h032;
    st_delay <= 15'h0000;
    wait_eq(O_LAG, 28'h1, 20, "fast stage");
    @(posedge clk_in);
    cp <= 1'b0;
    nx(3);
    chk("lag cp off", 28'h0, lag);
    nx(20);
    chk("relay cp off", 28'h0, relay);
    @(posedge clk_in);
    precharge <= 1'b1;
    nx(3);
    chk("relay pre 3", 28'h7, relay);
    @(posedge clk_in);
    pre_pumps <= 3'h7;
    nx(3);
    chk("relay pre cap", 28'hF, relay);
    @(posedge clk_in);
    precharge <= 1'b0;
    nx(3);
    chk("relay pre off", 28'h0, relay);
    $display("test mode done");
  endtask

  initial begin
    repeat (20) @(posedge clk_in);
    rst_b <= 1'b1;
    t_reset();
    t_setpoints();
    t_scale();
    t_fault();
    t_stage();
    t_destage();
    t_mode();
    final_report();
  end
endmodule
